// ---- erec_node.sv ----
// error record node: records reported errors and serves the registers
`timescale 1ns/1ps
// Overview of operation
// [RL1] overwrite sets state fields per encoding
// [RL2] corrected error gives nonzero corrected field
// [RL3] overwrite with uncorrected loads subtype
// [RL4] overwrite loads reported, poison, error codes
// [RL5] address valid and address per report
// [RL6] timestamp recorded, misc valid set
// [RL7] misc syndrome stored, misc valid set
// [RL8] no misc: keep flag if unrelated
// [RL9] overwrite or fresh record sets valid
// [RL10] status clear ignored if updated since read
// [RL11] keep sets only the matching state field
// [RL12] keep leaves subtype unchanged
// [RL13] keep leaves syndrome, address, timestamp alone
// [RL14] keep may log discarded error, misc valid
// [RL15] simultaneous: highest recorded, lower dropped
// [RL16] simultaneous countable errors: count one
// [RL17] count one repeat and one other
// [RL18] corrected field: transient, persistent, unknown
// [RL19] poison only for propagated deferred errors; the code also sets it for poisoned uncorrected errors
// [RL20] fresh deferral records poison clear
// [RL21] non-secure programmed msi never secure
// [RL22] one record update per clock cycle
module erec_node #(
	parameter int NSRC = 2,
	parameter bit TS_PRESENT = 1'b1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_nonsecure_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [NSRC-1:0] rpt_valid_i,
	input wire logic [3*NSRC-1:0] rpt_type_i,
	input wire logic [2*NSRC-1:0] rpt_ce_class_i,
	input wire logic [NSRC-1:0] rpt_repeat_i,
	input wire logic [NSRC-1:0] rpt_poison_i,
	input wire logic [NSRC-1:0] rpt_err_rep_i,
	input wire logic [8*NSRC-1:0] rpt_impl_error_code_i,
	input wire logic [8*NSRC-1:0] rpt_architected_error_code_i,
	input wire logic [NSRC-1:0] rpt_addr_valid_i,
	input wire logic [32*NSRC-1:0] rpt_addr_i,
	input wire logic [NSRC-1:0] rpt_misc_valid_i,
	input wire logic [32*NSRC-1:0] rpt_misc_i,
	output logic rec_valid_o,
	output logic msi_req_o,
	output logic [31:0] msi_addr_o,
	output logic msi_secure_o
);
	localparam int SW = (NSRC > 1) ? $clog2(NSRC) : 1;

	// priority of the error state held in a status word
	function automatic logic [2:0] rec_prio(input logic [31:0] st);
		logic [2:0] p;
		p = erec_pkg::TY_NONE;
		if (!st[erec_pkg::ST_VALID]) begin
			p = erec_pkg::TY_NONE;
		end else if (st[erec_pkg::ST_UNCORR]) begin
			unique case (st[erec_pkg::ST_UET_LO +: 2])
				erec_pkg::UET_UEO: p = erec_pkg::TY_UEO;
				erec_pkg::UET_UER: p = erec_pkg::TY_UER;
				erec_pkg::UET_UEU: p = erec_pkg::TY_UEU;
				erec_pkg::UET_UC: p = erec_pkg::TY_UC;
			endcase
		end else if (st[erec_pkg::ST_DEFERRED]) begin
			p = erec_pkg::TY_DE;
		end else if (st[erec_pkg::ST_CE_LO +: 2] != erec_pkg::CE_NONE) begin
			p = erec_pkg::TY_CE;
		end
		return p;
	endfunction

	// subtype code of an uncorrected error state
	function automatic logic [1:0] uet_code(input logic [2:0] ty);
		logic [1:0] u;
		u = erec_pkg::UET_UC;
		if (ty == erec_pkg::TY_UEO) begin
			u = erec_pkg::UET_UEO;
		end else if (ty == erec_pkg::TY_UER) begin
			u = erec_pkg::UET_UER;
		end else if (ty == erec_pkg::TY_UEU) begin
			u = erec_pkg::UET_UEU;
		end
		return u;
	endfunction

	// corrected field value, never zero for a corrected error
	function automatic logic [1:0] ce_code(input logic [1:0] cls);
		return (cls == erec_pkg::CE_NONE) ? erec_pkg::CE_UNKNOWN : cls;
	endfunction

	// valid report type of one source, none when idle
	function automatic logic [2:0] src_type(input int i,
			input logic [NSRC-1:0] v, input logic [3*NSRC-1:0] t);
		return v[i] ? t[3*i +: 3] : erec_pkg::TY_NONE;
	endfunction

	logic [31:0] status_q;
	logic [31:0] addr_q;
	logic [31:0] misc0_q;
	logic [31:0] misc1_q;
	logic [31:0] tstamp_q;
	logic [31:0] ts_cnt_q;
	logic [7:0] cnt_other_q;
	logic [7:0] cnt_repeat_q;
	logic [31:0] ctrl_q;
	logic [31:0] msi_addr_q;
	logic msi_secure_q;
	logic dirty_q;
	logic misc_unrel_q;
	logic [31:0] rdata_q;
	logic msi_req_q;

	// pick the highest priority report of this cycle
	logic [SW-1:0] sel;
	logic [2:0] sel_ty;
	logic any_ce;
	logic any_ce_rep;
	logic any_ce_oth;
	always_comb begin
		sel = '0;
		sel_ty = erec_pkg::TY_NONE;
		any_ce_rep = 1'b0;
		any_ce_oth = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			if (src_type(i, rpt_valid_i, rpt_type_i) > sel_ty) begin
				sel = SW'(i); // see [RL15]
				sel_ty = src_type(i, rpt_valid_i, rpt_type_i);
			end
			if (src_type(i, rpt_valid_i, rpt_type_i) == erec_pkg::TY_CE) begin
				any_ce_rep = any_ce_rep | rpt_repeat_i[i];
				any_ce_oth = any_ce_oth | ~rpt_repeat_i[i];
			end
		end
	end
	assign any_ce = any_ce_rep | any_ce_oth;

	// fields of the selected report
	wire logic [1:0] sel_cls = rpt_ce_class_i[2*sel +: 2];
	wire logic sel_pois = rpt_poison_i[sel];
	wire logic sel_er = rpt_err_rep_i[sel];
	wire logic [7:0] sel_impl_error_code = rpt_impl_error_code_i[8*sel +: 8];
	wire logic [7:0] sel_architected_error_code = rpt_architected_error_code_i[8*sel +: 8];
	wire logic sel_av = rpt_addr_valid_i[sel];
	wire logic [31:0] sel_addr = rpt_addr_i[32*sel +: 32];
	wire logic sel_mv = rpt_misc_valid_i[sel];
	wire logic [31:0] sel_misc = rpt_misc_i[32*sel +: 32];

	// record decision: overwrite on higher priority or empty record
	wire logic rec_en = ctrl_q[erec_pkg::CTRL_ENABLE];
	wire logic new_err = rec_en && (sel_ty != erec_pkg::TY_NONE);
	wire logic [2:0] old_ty = rec_prio(status_q);
	wire logic ovw = new_err && (sel_ty > old_ty);
	wire logic keep = new_err && !ovw;
	wire logic is_ue = sel_ty >= erec_pkg::TY_UEO;
	wire logic is_de = sel_ty == erec_pkg::TY_DE;
	wire logic is_ce = sel_ty == erec_pkg::TY_CE;
	wire logic keep_log = keep && ctrl_q[erec_pkg::CTRL_KEEP_MISC];

	// poison flag value on overwrite
	wire logic pois_val = sel_pois && (is_ue || is_de); // see [RL19] [RL20]

	// status word after an overwrite
	logic [31:0] st_ovw;
	always_comb begin
		st_ovw = status_q;
		st_ovw[erec_pkg::ST_VALID] = 1'b1; // see [RL9]
		if (is_ce) begin
			st_ovw[erec_pkg::ST_CE_LO +: 2] = ce_code(sel_cls); // see [RL2] [RL18]
			st_ovw[erec_pkg::ST_DEFERRED] = 1'b0; // see [RL1]
			st_ovw[erec_pkg::ST_UNCORR] = 1'b0;
		end else if (is_de) begin
			st_ovw[erec_pkg::ST_DEFERRED] = 1'b1; // see [RL1]
			st_ovw[erec_pkg::ST_UNCORR] = 1'b0;
		end else begin
			st_ovw[erec_pkg::ST_UNCORR] = 1'b1; // see [RL1]
			st_ovw[erec_pkg::ST_UET_LO +: 2] = uet_code(sel_ty); // see [RL3]
		end
		st_ovw[erec_pkg::ST_ERR_REP] = sel_er; // see [RL4]
		st_ovw[erec_pkg::ST_POISON] = pois_val;
		st_ovw[erec_pkg::ST_IMPL_ERROR_CODE_LO +: 8] = sel_impl_error_code;
		st_ovw[erec_pkg::ST_ARCHITECTED_ERROR_CODE_LO +: 8] = sel_architected_error_code;
		st_ovw[erec_pkg::ST_ADDR_VALID] = sel_av; // see [RL5]
		if (TS_PRESENT || sel_mv) begin
			st_ovw[erec_pkg::ST_MISC_VALID] = 1'b1; // see [RL6] [RL7]
		end else if (!misc_unrel_q) begin
			st_ovw[erec_pkg::ST_MISC_VALID] = 1'b0; // see [RL8]
		end
	end

	// status word after keeping the old syndrome
	logic [31:0] st_keep;
	always_comb begin
		st_keep = status_q; // see [RL12] [RL13]
		if (is_ce) begin
			st_keep[erec_pkg::ST_CE_LO +: 2] = ce_code(sel_cls); // see [RL11]
		end else if (is_de) begin
			st_keep[erec_pkg::ST_DEFERRED] = 1'b1; // see [RL11]
		end else begin
			st_keep[erec_pkg::ST_UNCORR] = 1'b1; // see [RL11]
		end
		if (keep_log) begin
			st_keep[erec_pkg::ST_MISC_VALID] = 1'b1; // see [RL14]
		end
	end

	// software clear of status, write one to clear
	logic [31:0] st_clr;
	always_comb begin
		st_clr = status_q;
		if (reg_wdata_i[erec_pkg::ST_VALID]) begin
			st_clr[erec_pkg::ST_VALID] = 1'b0;
		end
		if (reg_wdata_i[erec_pkg::ST_UNCORR]) begin
			st_clr[erec_pkg::ST_UNCORR] = 1'b0;
		end
		if (reg_wdata_i[erec_pkg::ST_DEFERRED]) begin
			st_clr[erec_pkg::ST_DEFERRED] = 1'b0;
		end
		if (reg_wdata_i[erec_pkg::ST_CE_LO +: 2] == 2'h3) begin
			st_clr[erec_pkg::ST_CE_LO +: 2] = erec_pkg::CE_NONE;
		end
		if (reg_wdata_i[erec_pkg::ST_ADDR_VALID]) begin
			st_clr[erec_pkg::ST_ADDR_VALID] = 1'b0;
		end
		if (reg_wdata_i[erec_pkg::ST_MISC_VALID]) begin
			st_clr[erec_pkg::ST_MISC_VALID] = 1'b0;
		end
		if (reg_wdata_i[erec_pkg::ST_ERR_REP]) begin
			st_clr[erec_pkg::ST_ERR_REP] = 1'b0;
		end
		if (reg_wdata_i[erec_pkg::ST_POISON]) begin
			st_clr[erec_pkg::ST_POISON] = 1'b0;
		end
	end

	// register port decode
	wire logic wr_st = reg_wr_i && (reg_addr_i == erec_pkg::OFS_STATUS);
	wire logic rd_st = reg_rd_i && (reg_addr_i == erec_pkg::OFS_STATUS);
	wire logic wr_cnt = reg_wr_i && (reg_addr_i == erec_pkg::OFS_COUNT);
	wire logic wr_ctrl = reg_wr_i && (reg_addr_i == erec_pkg::OFS_CTRL);
	wire logic wr_maddr = reg_wr_i && (reg_addr_i == erec_pkg::OFS_MSI_ADDR);
	wire logic wr_mcfg = reg_wr_i && (reg_addr_i == erec_pkg::OFS_MSI_CFG);
	wire logic clr_ok = wr_st && !dirty_q && !new_err; // see [RL10]

	// next status: hardware update wins over a clear
	wire logic [31:0] status_d = ovw ? st_ovw :
		keep ? st_keep :
		clr_ok ? st_clr : status_q;

	// read data mux, unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb begin
		unique case (reg_addr_i)
			erec_pkg::OFS_STATUS: rd_mux = status_q;
			erec_pkg::OFS_ADDR: rd_mux = addr_q;
			erec_pkg::OFS_MISC0: rd_mux = misc0_q;
			erec_pkg::OFS_MISC1: rd_mux = misc1_q;
			erec_pkg::OFS_TSTAMP: rd_mux = tstamp_q;
			erec_pkg::OFS_COUNT: rd_mux = {16'h0000, cnt_repeat_q, cnt_other_q};
			erec_pkg::OFS_CTRL: rd_mux = ctrl_q;
			erec_pkg::OFS_MSI_ADDR: rd_mux = msi_addr_q;
			erec_pkg::OFS_MSI_CFG: rd_mux = {31'h0, msi_secure_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// counter next values, one count per kind per cycle
	wire logic [7:0] cnt_oth_d = wr_cnt ? reg_wdata_i[7:0] :
		(rec_en && any_ce_oth) ? cnt_other_q + 8'h01 : cnt_other_q; // see [RL16] [RL17]
	wire logic [7:0] cnt_rep_d = wr_cnt ? reg_wdata_i[15:8] :
		(rec_en && any_ce_rep) ? cnt_repeat_q + 8'h01 : cnt_repeat_q; // see [RL16] [RL17]

	// record update, all fields in the same edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			status_q <= erec_pkg::STATUS_RESET;
			addr_q <= 32'h0000_0000;
			misc0_q <= 32'h0000_0000;
			misc1_q <= 32'h0000_0000;
			tstamp_q <= 32'h0000_0000;
			misc_unrel_q <= 1'b0;
		end else begin
			status_q <= status_d; // see [RL22]
			if (ovw && sel_av) begin
				addr_q <= sel_addr; // see [RL5]
			end
			if (ovw && TS_PRESENT) begin
				tstamp_q <= ts_cnt_q; // see [RL6]
			end
			if (ovw && sel_mv) begin
				misc0_q <= sel_misc; // see [RL7]
				misc_unrel_q <= 1'b0;
			end else if (keep_log) begin
				misc1_q <= {29'h0, sel_ty}; // see [RL14]
				misc_unrel_q <= 1'b1;
			end
		end
	end

	// updated-since-read tracking, update wins over read
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dirty_q <= 1'b0;
		end else if (new_err) begin
			dirty_q <= 1'b1; // see [RL10]
		end else if (rd_st) begin
			dirty_q <= 1'b0;
		end
	end

	// corrected error counters and timestamp source
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_other_q <= 8'h00;
			cnt_repeat_q <= 8'h00;
			ts_cnt_q <= 32'h0000_0000;
		end else begin
			cnt_other_q <= cnt_oth_d;
			cnt_repeat_q <= cnt_rep_d;
			ts_cnt_q <= ts_cnt_q + 32'h0000_0001;
		end
	end

	// control and msi configuration
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= erec_pkg::CTRL_RESET;
			msi_addr_q <= 32'h0000_0000;
			msi_secure_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {29'h0, reg_wdata_i[2:0]};
			end
			if (wr_maddr) begin
				msi_addr_q <= reg_wdata_i;
				if (reg_nonsecure_i) begin
					msi_secure_q <= 1'b0; // see [RL21]
				end
			end
			if (wr_mcfg) begin
				msi_secure_q <= reg_wdata_i[erec_pkg::MSI_SECURE] &&
					!reg_nonsecure_i; // see [RL21]
			end
		end
	end

	// read data and msi outputs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
			msi_req_q <= 1'b0;
		end else begin
			rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
			msi_req_q <= new_err && ctrl_q[erec_pkg::CTRL_MSI_EN];
		end
	end

	assign reg_rdata_o = rdata_q;
	assign rec_valid_o = status_q[erec_pkg::ST_VALID];
	assign msi_req_o = msi_req_q;
	assign msi_addr_o = msi_addr_q;
	assign msi_secure_o = msi_secure_q;
endmodule

// ---- erec_node_asserts.sv ----
// checker for the error record node ports
`timescale 1ns/1ps
module erec_node_asserts #(
	parameter int NSRC = 2,
	parameter bit TS_PRESENT = 1'b1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_nonsecure_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [NSRC-1:0] rpt_valid_i,
	input wire logic rec_valid_o,
	input wire logic msi_req_o,
	input wire logic [31:0] msi_addr_o,
	input wire logic msi_secure_o
);
	logic en_q;
	logic msien_q;
	// accepted report, status write and msi writes
	wire logic acc = |rpt_valid_i && en_q;
	wire logic st_wr = reg_wr_i && reg_addr_i == erec_pkg::OFS_STATUS;
	wire logic cfg_wr = reg_wr_i && (reg_addr_i == erec_pkg::OFS_MSI_CFG
		|| reg_addr_i == erec_pkg::OFS_MSI_ADDR);
	// shadow of the control enables
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			en_q <= 1'b1;
			msien_q <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == erec_pkg::OFS_CTRL) begin
			en_q <= reg_wdata_i[erec_pkg::CTRL_ENABLE];
			msien_q <= reg_wdata_i[erec_pkg::CTRL_MSI_EN];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence rec_s;
		acc;
	endsequence
	sequence rd_st_s;
		reg_rd_i && reg_addr_i == erec_pkg::OFS_STATUS;
	endsequence
	rec_set_a: assert property (acc |=> rec_valid_o)
		else $error("record not valid after report");
	rec_hold_a: assert property (rec_valid_o && !st_wr |=> rec_valid_o)
		else $error("record valid dropped without clear");
	rec_rise_a: assert property ($rose(rec_valid_o) |-> $past(acc))
		else $error("record valid rose without report");
	status_read_a: assert property (rec_s ##[1:2] rd_st_s |=> reg_rdata_o[31])
		else $error("status read missed fresh record");
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data not zero outside read");
	rdata_unmap_a: assert property (reg_rd_i
		&& reg_addr_i > erec_pkg::OFS_MSI_CFG |=> reg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	msi_req_a: assert property (acc && msien_q |=> msi_req_o)
		else $error("msi request missing");
	msi_cause_a: assert property (msi_req_o |-> $past(acc) && $past(msien_q))
		else $error("msi request without cause");
	msi_ns_a: assert property (cfg_wr && reg_nonsecure_i |=> !msi_secure_o)
		else $error("non-secure write left secure msi target");
	msi_addr_a: assert property (reg_wr_i && !reg_nonsecure_i
		&& reg_addr_i == erec_pkg::OFS_MSI_ADDR |=> msi_addr_o == $past(reg_wdata_i))
		else $error("msi address not stored");
endmodule
bind erec_node erec_node_asserts #(.NSRC(NSRC), .TS_PRESENT(TS_PRESENT)) u_chk (
	.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_nonsecure_i, .reg_rdata_o, .rpt_valid_i, .rec_valid_o, .msi_req_o,
	.msi_addr_o, .msi_secure_o);

// ---- erec_pkg.sv ----
// constants for the error record update block
package erec_pkg;
	// register offsets, byte addresses on the register port
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_MISC0 = 8'h08;
	localparam logic [7:0] OFS_MISC1 = 8'h0c;
	localparam logic [7:0] OFS_TSTAMP = 8'h10;
	localparam logic [7:0] OFS_COUNT = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_MSI_ADDR = 8'h1c;
	localparam logic [7:0] OFS_MSI_CFG = 8'h20;
	// status field positions
	localparam int ST_VALID = 31;
	localparam int ST_ADDR_VALID = 30;
	localparam int ST_UNCORR = 29;
	localparam int ST_ERR_REP = 28;
	localparam int ST_MISC_VALID = 26;
	localparam int ST_CE_LO = 24;
	localparam int ST_DEFERRED = 23;
	localparam int ST_POISON = 22;
	localparam int ST_UET_LO = 20;
	localparam int ST_IMPL_ERROR_CODE_LO = 8;
	localparam int ST_ARCHITECTED_ERROR_CODE_LO = 0;
	// reported error state codes, higher value is higher priority
	localparam logic [2:0] TY_NONE = 3'h0;
	localparam logic [2:0] TY_CE = 3'h1;
	localparam logic [2:0] TY_DE = 3'h2;
	localparam logic [2:0] TY_UEO = 3'h3;
	localparam logic [2:0] TY_UER = 3'h4;
	localparam logic [2:0] TY_UEU = 3'h5;
	localparam logic [2:0] TY_UC = 3'h6;
	// uncorrected subtype encodings
	localparam logic [1:0] UET_UEO = 2'h2;
	localparam logic [1:0] UET_UER = 2'h3;
	localparam logic [1:0] UET_UEU = 2'h1;
	localparam logic [1:0] UET_UC = 2'h0;
	// corrected field encodings
	localparam logic [1:0] CE_NONE = 2'h0;
	localparam logic [1:0] CE_TRANSIENT = 2'h1;
	localparam logic [1:0] CE_PERSIST = 2'h2;
	localparam logic [1:0] CE_UNKNOWN = 2'h3;
	// control register bits
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_KEEP_MISC = 1;
	localparam int CTRL_MSI_EN = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// msi config bits
	localparam int MSI_SECURE = 0;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
endpackage

// ---- erec_src_model.sv ----
// error source model: components reporting errors to the node
`timescale 1ns/1ps
module erec_src_model #(
	parameter int NSRC = 2
) (
	input wire logic clk_i,
	output logic [NSRC-1:0] valid_o,
	output logic [3*NSRC-1:0] type_o,
	output logic [2*NSRC-1:0] class_o,
	output logic [NSRC-1:0] repeat_o,
	output logic [NSRC-1:0] poison_o,
	output logic [NSRC-1:0] err_rep_o,
	output logic [8*NSRC-1:0] impl_error_code_o,
	output logic [8*NSRC-1:0] architected_error_code_o,
	output logic [NSRC-1:0] addr_valid_o,
	output logic [32*NSRC-1:0] addr_o,
	output logic [NSRC-1:0] misc_valid_o,
	output logic [32*NSRC-1:0] misc_o
);
	logic [NSRC-1:0] pv = '0;
	logic [3*NSRC-1:0] pt = '0;
	logic [2*NSRC-1:0] pc = '0;
	logic [NSRC-1:0] pr = '0;
	logic [NSRC-1:0] pp = '0;
	logic [NSRC-1:0] pa = '0;
	// all lines quiet at time zero
	initial begin
		{valid_o, type_o, class_o, repeat_o, poison_o, err_rep_o} = '0;
		{impl_error_code_o, architected_error_code_o, addr_valid_o, addr_o, misc_valid_o, misc_o} = '0;
	end
	// note one report for source s, sent by the next fire
	task automatic post(input int s, input logic [2:0] ty, input logic [1:0] cl,
		input logic rp, input logic pn, input logic av);
		pv[s] = 1'b1;
		pt[3*s+:3] = ty;
		pc[2*s+:2] = cl;
		pr[s] = rp;
		pp[s] = pn;
		pa[s] = av;
	endtask
	// present the noted reports for one cycle, then scramble the payload
	task automatic fire();
		@(posedge clk_i);
		valid_o <= pv;
		type_o <= pt;
		class_o <= pc;
		repeat_o <= pr;
		poison_o <= pp;
		err_rep_o <= pv;
		addr_valid_o <= pa;
		misc_valid_o <= pa;
		for (int s = 0; s < NSRC; s++) begin
			impl_error_code_o[8*s+:8] <= {5'h14, pt[3*s+:3]};
			architected_error_code_o[8*s+:8] <= 8'h50 + 8'(s);
			addr_o[32*s+:32] <= {29'h0200_0000, pt[3*s+:3]};
			misc_o[32*s+:32] <= {29'h1800_0000, pt[3*s+:3]};
		end
		@(posedge clk_i);
		valid_o <= '0;
		{type_o, class_o, impl_error_code_o, architected_error_code_o, addr_o, misc_o} <=
			~{type_o, class_o, impl_error_code_o, architected_error_code_o, addr_o, misc_o};
		pv = '0;
	endtask
endmodule

// ---- error_record_syndrome_update_tb.sv ----
// self-checking bench for the error record node
`timescale 1ns/1ps
module error_record_syndrome_update_tb;
	localparam logic [7:0] S = erec_pkg::OFS_STATUS;
	localparam logic [31:0] M_DE = 32'hf7c0_ffff;
	localparam logic [31:0] M_ALL = 32'hf7f0_ffff;
	localparam logic [31:0] M_FL = 32'hf7c0_0000;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic reg_nonsecure_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [31:0] msi_addr_o;
	logic rec_valid_o;
	logic msi_req_o;
	logic msi_secure_o;
	wire logic [1:0] rpt_valid_i, rpt_repeat_i, rpt_poison_i, rpt_err_rep_i;
	wire logic [1:0] rpt_addr_valid_i, rpt_misc_valid_i;
	wire logic [5:0] rpt_type_i;
	wire logic [3:0] rpt_ce_class_i;
	wire logic [15:0] rpt_impl_error_code_i, rpt_architected_error_code_i;
	wire logic [63:0] rpt_addr_i, rpt_misc_i;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic rd_d = 1'b0;
	logic [63:0] exp_q[$];
	logic [63:0] e;
	logic [1:0] cl;
	erec_node #(.NSRC(2), .TS_PRESENT(1'b1)) u_dut (.clk_i, .sys_rst_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_nonsecure_i,
		.reg_rdata_o, .rpt_valid_i, .rpt_type_i, .rpt_ce_class_i, .rpt_repeat_i,
		.rpt_poison_i, .rpt_err_rep_i, .rpt_impl_error_code_i, .rpt_architected_error_code_i,
		.rpt_addr_valid_i, .rpt_addr_i, .rpt_misc_valid_i, .rpt_misc_i,
		.rec_valid_o, .msi_req_o, .msi_addr_o, .msi_secure_o);
	erec_src_model #(.NSRC(2)) u_src (.clk_i, .valid_o(rpt_valid_i),
		.type_o(rpt_type_i), .class_o(rpt_ce_class_i), .repeat_o(rpt_repeat_i),
		.poison_o(rpt_poison_i), .err_rep_o(rpt_err_rep_i), .impl_error_code_o(rpt_impl_error_code_i),
		.architected_error_code_o(rpt_architected_error_code_i), .addr_valid_o(rpt_addr_valid_i),
		.addr_o(rpt_addr_i), .misc_valid_o(rpt_misc_valid_i),
		.misc_o(rpt_misc_i));
	always #5 clk_i = ~clk_i;
	// cycle ceiling against hangs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end
	// compare each read result with the oldest note
	always @(posedge clk_i) rd_d <= reg_rd_i;
	always @(negedge clk_i) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			total_checks++;
			if ((reg_rdata_o & e[63:32]) !== e[31:0]) begin
				errors++;
				$display("wrong value at %0t: got %h expected %h", $time,
					reg_rdata_o & e[63:32], e[31:0]);
			end
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ns);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_nonsecure_i <= ns;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m);
		exp_q.push_back({m, x & m});
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_nonsecure_i <= 1'b0;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask
	// direct compare of a settled output
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// read then write ones to clear the record
	task automatic clr();
		rd(S, 32'h0, 32'h0);
		wr(S, 32'hffff_ffff, 1'b0);
	endtask
	// status word; f holds V AV UE ER MV DE PN
	function automatic logic [31:0] st(input logic [6:0] f,
		input logic [1:0] ce, input logic [1:0] ut, input logic [2:0] ty);
		st = {f[6:3], 1'b0, f[2], ce, f[1:0], ut, 4'h0, 5'h14, ty, 8'h50};
	endfunction
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(11));
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wr(8'h24, 32'hffff_ffff, 1'b0);
		rd(S, erec_pkg::STATUS_RESET, '1);
		rd(erec_pkg::OFS_CTRL, erec_pkg::CTRL_RESET, '1);
		rd(8'h24, 32'h0, '1);
		// fresh deferred error with address and misc
		u_src.post(0, erec_pkg::TY_DE, 2'h0, 1'b0, 1'b0, 1'b1);
		u_src.fire();
		rd(S, st(7'b1101110, 2'h0, 2'h0, erec_pkg::TY_DE), M_DE);
		rd(erec_pkg::OFS_ADDR, 32'h1000_0002, '1);
		rd(erec_pkg::OFS_MISC0, 32'hc000_0002, '1);
		// lower corrected error is kept and counted
		u_src.post(1, erec_pkg::TY_CE, erec_pkg::CE_TRANSIENT, 1'b0, 1'b0, 1'b0);
		u_src.fire();
		rd(S, st(7'b1101110, 2'h1, 2'h0, erec_pkg::TY_DE), M_DE);
		rd(erec_pkg::OFS_COUNT, 32'h1, 32'hffff);
		// poisoned uncontainable error overwrites, no address
		u_src.post(0, erec_pkg::TY_UC, 2'h0, 1'b0, 1'b1, 1'b0);
		u_src.fire();
		rd(S, st(7'b1011111, 2'h1, erec_pkg::UET_UC, erec_pkg::TY_UC), M_ALL);
		u_src.post(1, erec_pkg::TY_UER, 2'h0, 1'b0, 1'b0, 1'b1);
		u_src.fire();
		rd(S, st(7'b1011111, 2'h1, erec_pkg::UET_UC, erec_pkg::TY_UC), M_ALL);
		clr();
		rd(S, 32'h0, M_FL);
		// simultaneous reports, highest one recorded
		u_src.post(0, erec_pkg::TY_UER, 2'h0, 1'b0, 1'b0, 1'b1);
		u_src.post(1, erec_pkg::TY_DE, 2'h0, 1'b0, 1'b0, 1'b0);
		u_src.fire();
		rd(S, st(7'b1111100, 2'h0, erec_pkg::UET_UER, erec_pkg::TY_UER), M_ALL);
		// clear after a new report is ignored
		rd(S, 32'h0, 32'h0);
		u_src.post(1, erec_pkg::TY_CE, erec_pkg::CE_PERSIST, 1'b1, 1'b0, 1'b0);
		u_src.fire();
		wr(S, 32'hffff_ffff, 1'b0);
		rd(S, st(7'b1111100, 2'h2, erec_pkg::UET_UER, erec_pkg::TY_UER), M_ALL);
		rd(erec_pkg::OFS_COUNT, 32'h0101, 32'hffff);
		// recording disabled
		clr();
		wr(erec_pkg::OFS_CTRL, 32'h0, 1'b0);
		u_src.post(0, erec_pkg::TY_UC, 2'h0, 1'b0, 1'b0, 1'b0);
		u_src.fire();
		rd(S, 32'h0, M_FL);
		// msi target and a tied pair of reports
		wr(erec_pkg::OFS_CTRL, 32'h5, 1'b0);
		wr(erec_pkg::OFS_MSI_ADDR, 32'h8000_0040, 1'b0);
		wr(erec_pkg::OFS_MSI_CFG, 32'h1, 1'b0);
		rd(erec_pkg::OFS_MSI_CFG, 32'h1, 32'h1);
		wr(erec_pkg::OFS_MSI_CFG, 32'h1, 1'b1);
		rd(erec_pkg::OFS_MSI_CFG, 32'h0, 32'h1);
		u_src.post(0, erec_pkg::TY_DE, 2'h0, 1'b0, 1'b0, 1'b0);
		u_src.post(1, erec_pkg::TY_DE, 2'h0, 1'b0, 1'b1, 1'b0);
		u_src.fire();
		#1;
		chk({31'h0, msi_req_o}, 32'h1);
		chk({31'h0, rec_valid_o}, 32'h1);
		chk(msi_addr_o, 32'h8000_0040);
		chk({31'h0, msi_secure_o}, 32'h0);
		rd(S, st(7'b1001110, 2'h0, 2'h0, erec_pkg::TY_DE), M_DE);
		// random corrected classes into a fresh record
		for (int i = 0; i < 8; i++) begin
			cl = 2'($urandom());
			clr();
			u_src.post(i % 2, erec_pkg::TY_CE, cl, 1'($urandom()), 1'b0, 1'b0);
			u_src.fire();
			rd(S, {1'b1, 5'h0, (cl == 2'h0) ? erec_pkg::CE_UNKNOWN : cl, 24'h0},
				32'h8300_0000);
		end
		repeat (3) @(posedge clk_i);
		test_done();
	end
endmodule
